// ### sar_adc_ctrl.sv
// Conversion control, output coding and serial shift-out of a SAR ADC
`timescale 1ns/10ps
`default_nettype none
module sar_adc_ctrl
  import sar_pkg::*;
#(
  parameter bit BIPOLAR = 1'b1
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // Host pins
  input  wire logic                conversion_start_n,
  input  wire logic                serial_clk,
  output logic                     serial_data_out,
  output logic                     serial_data_oe,
  output logic                     busy,
  // Analog core
  input  wire logic                comp_above,
  output logic      [RES_BITS-1:0] dac_code,
  output logic                     track_hold,
  output logic                     power_down,
  // Result stream
  output logic                     result_valid,
  input  wire logic                result_ready,
  output logic      [RES_BITS-1:0] result_data
);

  // ****************************************************************
  // Pin synchronisers and edge detect
  // ****************************************************************
  logic [2:0] cs_q;
  logic [2:0] sc_q;
  logic       cs_fall;
  logic       cs_rise;
  logic       sc_fall;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cs_q <= 3'h7;
      sc_q <= 3'h0;
    end
    else
    begin
      cs_q <= {cs_q[1:0], conversion_start_n};
      sc_q <= {sc_q[1:0], serial_clk};
    end
  end

  assign cs_fall = cs_q[2] && !cs_q[1];
  assign cs_rise = !cs_q[2] && cs_q[1];
  assign sc_fall = sc_q[2] && !sc_q[1];

  // ****************************************************************
  // Sequencer and SAR
  // ****************************************************************
  state_t               st_q, st_d;
  logic [CNT_W-1:0]     cnt_q, cnt_d;
  logic [CNT_W-1:0]     lim_q, lim_d;
  logic [CNT_W-1:0]     ofs_q, ofs_d;
  logic [CNT_W-1:0]     step_q, step_d;
  logic [3:0]           bi_q, bi_d;
  logic [RES_BITS-1:0]  sar_q, sar_d;
  logic                 hold_q, hold_d;
  logic                 done_q, done_d;
  logic                 finish;
  logic                 push_ready;
  logic [RES_BITS-1:0]  code;

  // Offset binary from the SAR; MSB flip makes twos complement
  assign code = {sar_q[RES_BITS-1] ^ BIPOLAR,
                 sar_q[RES_BITS-2:0]};

  // Full result FIFO stalls completion rather than losing a sample;
  // a start edge in that cycle defers completion by one cycle
  assign finish = (st_q == ST_CONV) && (cnt_q == lim_q - 1'b1) &&
                  done_q && push_ready && !cs_fall;

  always_comb
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    lim_d  = lim_q;
    ofs_d  = ofs_q;
    step_d = step_q;
    bi_d   = bi_q;
    sar_d  = sar_q;
    hold_d = hold_q;
    done_d = done_q;
    case (st_q)
      ST_TRACK:
      begin
        if (cs_fall)
        begin
          st_d   = ST_CONV;
          cnt_d  = '0;
          lim_d  = CNT_W'(CONV_HS_CYC);
          hold_d = 1'b1;
          sar_d  = RES_BITS'(1) << (RES_BITS - 1);
          bi_d   = 4'(RES_BITS - 1);
          step_d = CNT_W'(STEP_CYC - 1);
          ofs_d  = '0;
          done_d = 1'b0;
        end
      end
      ST_CONV:
      begin
        if (cnt_q != lim_q - 1'b1)
          cnt_d = cnt_q + 1'b1;
        if (!hold_q && !done_q && cnt_q == ofs_q)
        begin
          hold_d = 1'b1;
          sar_d  = RES_BITS'(1) << (RES_BITS - 1);
          bi_d   = 4'(RES_BITS - 1);
          step_d = CNT_W'(STEP_CYC - 1);
        end
        else if (hold_q && !done_q)
        begin
          step_d = step_q - 1'b1;
          if (step_q == '0)
          begin
            // Oscillator tick: keep trial bit only if input is above
            step_d = CNT_W'(STEP_CYC - 1);
            if (!comp_above)
              sar_d[bi_q] = 1'b0;
            if (bi_q == 4'h0)
              done_d = 1'b1;
            else
            begin
              bi_d = bi_q - 1'b1;
              sar_d[bi_q - 1'b1] = 1'b1;
            end
          end
        end
        if (finish)
        begin
          hold_d = 1'b0;
          // Start still low at the end selects auto-sleep
          st_d = cs_q[1] ? ST_TRACK : ST_SLEEP;
        end
      end
      ST_SLEEP:
      begin
        if (cs_rise)
        begin
          st_d  = ST_WAKE;
          cnt_d = '0;
        end
      end
      ST_WAKE:
      begin
        cnt_d = cnt_q + 1'b1;
        if (cs_fall)
        begin
          // Short pulse: hold waits for wake-up, 10 us overall
          st_d   = ST_CONV;
          lim_d  = CNT_W'(CONV_AS_CYC);
          ofs_d  = CNT_W'(WAKE_CYC) - cnt_q;
          cnt_d  = '0;
          done_d = 1'b0;
        end
        else if (cnt_q == CNT_W'(WAKE_CYC - 1))
          st_d = ST_TRACK;
      end
      default:
        st_d = ST_TRACK;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q   <= ST_TRACK;
      cnt_q  <= '0;
      lim_q  <= CNT_W'(CONV_HS_CYC);
      ofs_q  <= '0;
      step_q <= '0;
      bi_q   <= '0;
      sar_q  <= '0;
      hold_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      lim_q  <= lim_d;
      ofs_q  <= ofs_d;
      step_q <= step_d;
      bi_q   <= bi_d;
      sar_q  <= sar_d;
      hold_q <= hold_d;
      done_q <= done_d;
    end
  end

  assign busy       = (st_q == ST_CONV);
  assign track_hold = hold_q;
  assign power_down = (st_q == ST_SLEEP);
  assign dac_code   = sar_q;

  // ****************************************************************
  // Output shift register
  // ****************************************************************
  logic [WORD_BITS-1:0] sh_q;
  logic [WORD_BITS-1:0] sh_d;
  logic [4:0]           bit_q;
  logic [4:0]           bit_d;

  always_comb
  begin
    sh_d  = sh_q;
    bit_d = bit_q;
    if (cs_fall)
    begin
      sh_d  = '0;
      bit_d = '0;
    end
    else if (finish)
    begin
      sh_d  = {2'h0, code};
      bit_d = '0;
    end
    else if (sc_fall)
    begin
      // Extra clocks move the register on; the line stays released
      sh_d = {sh_q[WORD_BITS-2:0], 1'b0};
      if (bit_q != 5'(WORD_BITS))
        bit_d = bit_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sh_q  <= '0;
      bit_q <= 5'(WORD_BITS);
    end
    else
    begin
      sh_q  <= sh_d;
      bit_q <= bit_d;
    end
  end

  assign serial_data_out = sh_q[WORD_BITS-1];
  assign serial_data_oe  = (bit_q != 5'(WORD_BITS));

  // ****************************************************************
  // Result buffer
  // ****************************************************************
  sar_fifo #(
    .WIDTH (RES_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (finish),
    .in_ready  (push_ready),
    .in_data   (code),
    .out_valid (result_valid),
    .out_ready (result_ready),
    .out_data  (result_data)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_busy_on_start: assert property (st_q == ST_TRACK && cs_fall |=>
                                    busy && track_hold)
    else $error("busy did not rise on start");
  a_conv_bound: assert property (busy |-> cnt_q < lim_q)
    else $error("conversion counter overran");
  a_hs_length: assert property (st_q == ST_TRACK && cs_fall |=>
                                lim_q == CNT_W'(CONV_HS_CYC))
    else $error("wrong high-sampling length");
  a_done_before: assert property (finish |-> done_q && bi_q == 4'h0)
    else $error("completed before 14 decisions");
  a_load_word: assert property ($fell(busy) |->
                                sh_q == {2'h0, $past(code)})
    else $error("shift register not loaded");
  a_coding_msb: assert property ($fell(busy) |->
                                 sh_q[13] == ($past(sar_q[13]) ^ BIPOLAR))
    else $error("output coding wrong");
  a_sleep_entry: assert property ($fell(busy) && !$past(cs_q[1]) |->
                                  power_down)
    else $error("no sleep after conversion");
  a_wake_rise: assert property (power_down && cs_rise |=> !power_down)
    else $error("rising start did not wake");
  a_sr_reset: assert property (cs_fall |=> sh_q == '0 && bit_q == 5'h0)
    else $error("start edge did not reset register");
  a_tristate: assert property (sc_fall && !cs_fall && !finish &&
                               bit_q == 5'(WORD_BITS - 1) |=>
                               !serial_data_oe)
    else $error("data line driven after 16 bits");
  a_hold_track: assert property (!busy |-> !track_hold)
    else $error("hold outside conversion");

  c_mode1: cover property ($fell(busy) && !power_down);
  c_sleep: cover property ($rose(power_down));
  c_wake_conv: cover property (st_q == ST_WAKE && cs_fall);
  c_full_read: cover property ($fell(serial_data_oe));

endmodule // sar_adc_ctrl
`default_nettype wire

// ### sar_pkg.sv
// Shared constants and types for the SAR conversion controller
package sar_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int CONV_HS_NS    = 5000;   // High-sampling conversion
  localparam int CONV_AS_NS    = 10000;  // Auto-sleep, wake included
  localparam int WAKE_NS       = 5000;
  // Longest times round down
  localparam int CONV_HS_CYC   = CONV_HS_NS / CLK_PERIOD_NS;
  localparam int CONV_AS_CYC   = CONV_AS_NS / CLK_PERIOD_NS;
  localparam int WAKE_CYC      = WAKE_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Converter and serial word layout
  // ****************************************************************
  localparam int RES_BITS      = 14;
  localparam int WORD_BITS     = 16;
  localparam int SAR_STEPS     = WORD_BITS;
  // Internal oscillator period, in clk cycles
  localparam int STEP_CYC      = CONV_HS_CYC / SAR_STEPS;
  localparam int CNT_W         = 10;
  localparam int FIFO_DEPTH    = 8;

  typedef enum logic [1:0] {
    ST_TRACK,
    ST_CONV,
    ST_SLEEP,
    ST_WAKE
  } state_t;

endpackage

// ### sar_fifo.sv
// Result FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module sar_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      wr_d;
  logic [AW:0]      rd_q;
  logic [AW:0]      rd_d;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty
  assign in_ready  = !((wr_q[AW] != rd_q[AW]) &&
                       (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem_q[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_q[AW-1:0]] <= in_data;
  end

endmodule // sar_fifo
`default_nettype wire

// ### sar_host_model.sv
// Host side model: start pin and serial reader
`timescale 1ns/10ps
`default_nettype none
module sar_host_model (
  // Clock
  input  wire logic clk,
  // Host pins
  output logic      conversion_start_n,
  output logic      serial_clk,
  input  wire logic data_b,
  input  wire logic data_u
);
  initial
  begin
    conversion_start_n = 1'b1;
    serial_clk         = 1'b0;
  end

  // Pin set on an edge, then held n cycles
  task automatic drive_start(input logic lvl, input int n);
    @(posedge clk);
    conversion_start_n <= lvl;
    repeat (n) @(posedge clk);
  endtask

  // Quiet gap first: settling before the next sample point
  task automatic pulse_start();
    repeat (18) @(posedge clk);
    drive_start(1'b0, 2);
    drive_start(1'b1, 0);
  endtask

  // Serial clock idles low; 160 ns period, bit taken before each fall
  task automatic read_word(input int nb, output logic [15:0] wb,
                           output logic [15:0] wu);
    wb = '0;
    wu = '0;
    for (int i = 0; i < nb; i++)
    begin
      @(posedge clk);
      serial_clk <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      wb = {wb[14:0], data_b};
      wu = {wu[14:0], data_u};
      @(posedge clk);
      serial_clk <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule // sar_host_model
`default_nettype wire

// ### sar_adc_ctrl_bench.sv
// Self-checking bench for the SAR conversion controller
`timescale 1ns/10ps
`default_nettype none
module sar_adc_ctrl_bench
  import sar_pkg::*;
;
  logic                clk;
  logic                nrst;
  logic                conversion_start_n;
  logic                serial_clk;
  logic                result_ready;
  logic [RES_BITS-1:0] level;
  logic [RES_BITS-1:0] dac_b, dac_u, data_b, data_u;
  logic                sd_b, sd_u, oe_b, oe_u, busy_b, busy_u;
  logic                th_b, th_u, pd_b, pd_u, rv_b, rv_u;
  logic                comp_b, comp_u;
  int                  n_errors = 0;
  int                  checked = 0;

  // Ideal comparator: input at k LSB converts to raw code k
  assign comp_b = (level >= dac_b);
  assign comp_u = (level >= dac_u);
  // Released data line reads as the opposite of serial_data_out
  logic                line_b, line_u;
  assign line_b = oe_b ? sd_b : !sd_b;
  assign line_u = oe_u ? sd_u : !sd_u;

  sar_adc_ctrl #(.BIPOLAR(1'b1)) dut (.clk(clk), .nrst(nrst),
    .conversion_start_n(conversion_start_n), .serial_clk(serial_clk),
    .serial_data_out(sd_b), .serial_data_oe(oe_b), .busy(busy_b),
    .comp_above(comp_b), .dac_code(dac_b), .track_hold(th_b),
    .power_down(pd_b), .result_valid(rv_b),
    .result_ready(result_ready), .result_data(data_b));
  sar_adc_ctrl #(.BIPOLAR(1'b0)) dut_u (.clk(clk), .nrst(nrst),
    .conversion_start_n(conversion_start_n), .serial_clk(serial_clk),
    .serial_data_out(sd_u), .serial_data_oe(oe_u), .busy(busy_u),
    .comp_above(comp_u), .dac_code(dac_u), .track_hold(th_u),
    .power_down(pd_u), .result_valid(rv_u),
    .result_ready(result_ready), .result_data(data_u));
  sar_host_model host (.clk(clk), .conversion_start_n(conversion_start_n),
    .serial_clk(serial_clk), .data_b(line_b), .data_u(line_u));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ********************
  // Shared tasks
  // ********************
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Counts cycles until busy equals v; a hang ends the run
  task automatic wait_busy(input logic v, input int lim, output int n);
    n = 0;
    while (busy_b !== v)
    begin
      @(negedge clk);
      n++;
      if (n > lim)
      begin
        check("busy wait", busy_b, v);
        finish_test();
      end
    end
  endtask

  task automatic pop();
    @(posedge clk);
    result_ready <= 1'b1;
    @(posedge clk);
    result_ready <= 1'b0;
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic conv_hs(input logic [13:0] lv);
    int n;
    logic [15:0] wb, wu;
    logic [13:0] eb;
    eb = 14'(lv - 14'h2000);
    @(posedge clk);
    level <= lv;
    host.pulse_start();
    wait_busy(1'b1, 20, n);
    check("hold", th_b, 1);
    check("busy pair", busy_u, 1);
    wait_busy(1'b0, 1000, n);
    check("busy cycles", n, CONV_HS_CYC);
    check("track", th_b, 0);
    check("awake", pd_b, 0);
    repeat (3) @(negedge clk);
    check("valid", rv_b, 1);
    check("twos", data_b, eb);
    check("binary", data_u, lv);
    check("oe load", oe_b, 1);
    pop();
    host.read_word(16, wb, wu);
    check("word b", wb, {2'b00, eb});
    check("word u", wu, {2'b00, lv});
    repeat (6) @(negedge clk);
    check("released", oe_b, 0);
  endtask

  task automatic conv_as();
    int n;
    @(posedge clk);
    level <= 14'h2abc;
    host.drive_start(1'b0, 0);
    wait_busy(1'b1, 20, n);
    wait_busy(1'b0, 1000, n);
    check("first", n, CONV_HS_CYC);
    check("sleep", pd_b, 1);
    pop();
    host.drive_start(1'b1, 20);
    check("wake", pd_b, 0);
    host.drive_start(1'b0, 0);
    wait_busy(1'b1, 20, n);
    check("hold late", th_b, 0);
    wait_busy(1'b0, 1000, n);
    check("sleep cycles", n, CONV_AS_CYC);
    check("sleep again", pd_b, 1);
    repeat (3) @(negedge clk);
    check("sleep data", data_u, 14'h2abc);
    pop();
    host.drive_start(1'b1, 300);
    check("wake over", pd_b, 0);
  endtask

  task automatic shift_reset();
    int n;
    logic [15:0] wb, wu;
    conv_hs(14'h3fff);
    host.pulse_start();
    wait_busy(1'b1, 20, n);
    wait_busy(1'b0, 1000, n);
    pop();
    // Four bits of a fresh word, then a start edge mid-word
    host.read_word(4, wb, wu);
    check("part word", wu, 16'h0003);
    check("part word b", wb, 16'h0001);
    host.pulse_start();
    wait_busy(1'b1, 20, n);
    check("cleared", sd_u, 0);
    wait_busy(1'b0, 1000, n);
    repeat (3) @(posedge clk);
    pop();
  endtask

  // Nine results against eight places: the last one stalls busy
  task automatic fifo_fill();
    int n;
    int k;
    for (int i = 0; i < 9; i++)
    begin
      @(posedge clk);
      level <= 14'(i * 16'h0111);
      host.pulse_start();
      wait_busy(1'b1, 20, n);
      if (i < 8)
        wait_busy(1'b0, 1000, n);
    end
    repeat (300) @(negedge clk);
    check("stall", busy_b, 1);
    @(posedge clk);
    result_ready <= 1'b1;
    k = 0;
    // Ready stays high: every head seen here leaves at the next edge
    repeat (20)
    begin
      @(negedge clk);
      if (rv_b === 1'b1)
      begin
        check("order", data_u, 14'(k * 16'h0111));
        k++;
      end
    end
    wait_busy(1'b0, 20, n);
    check("beats", k, 9);
    @(posedge clk);
    result_ready <= 1'b0;
  endtask

  localparam logic [13:0] LV [5] = '{14'h0000, 14'h0001, 14'h2000,
                                     14'h3fff, 14'h1fff};

  initial
  begin
    nrst = 1'b0;
    result_ready = 1'b0;
    level = '0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    check("reset busy", busy_b, 0);
    foreach (LV[i])
      conv_hs(LV[i]);
    conv_as();
    shift_reset();
    fifo_fill();
    finish_test();
  end
endmodule // sar_adc_ctrl_bench
`default_nettype wire
